// ---- itw_checker.sv ----
// checker: port-level assertions for the interval timer and watchdog
`timescale 1ns/1ps
module itw_checker
    import itw_pkg::*;
(
    // apb side
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // events and pins
    input wire logic interval_irq_ack,
    input wire logic watchdog_irq_ack,
    input wire logic interval_overflow_flag,
    input wire logic watchdog_irq_flag,
    input wire logic wdt_reset_req,
    input wire logic reset_pin_o,
    input wire logic reset_pin_oe
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    logic mapped;
    logic st_wr;
    assign acc = psel && penable;
    assign mapped = paddr inside {ITW_ADDR_CTRL, ITW_ADDR_WDT, ITW_ADDR_STAT};
    assign st_wr = acc && pwrite && paddr == ITW_ADDR_STAT;
    ////////////////////////////////////////////////////////////////////////
    sequence s_pulse16;
        wdt_reset_req [*8] ##1 wdt_reset_req [*8];
    endsequence
    sequence s_released;
        !wdt_reset_req;
    endsequence
    property p_ready; pready; endproperty
    property p_slverr; pslverr == (acc && !mapped); endproperty
    property p_rd_idle; !(acc && !pwrite) |-> prdata == 32'h0; endproperty
    property p_rd_ctrl; acc && !pwrite && paddr == ITW_ADDR_CTRL |-> prdata[31:8] == 24'h0; endproperty
    property p_pin; reset_pin_oe == wdt_reset_req && !reset_pin_o; endproperty
    property p_pulse; $rose(wdt_reset_req) |-> s_pulse16 ##1 s_released; endproperty
    property p_ihold; interval_overflow_flag && !interval_irq_ack && !st_wr |=> interval_overflow_flag; endproperty
    property p_whold; watchdog_irq_flag && !watchdog_irq_ack && !st_wr |=> watchdog_irq_flag; endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    a_slverr: assert property (p_slverr) else $error("pslverr wrong");
    a_rd_idle: assert property (p_rd_idle) else $error("prdata not zero");
    a_rd_ctrl: assert property (p_rd_ctrl) else $error("counter read too wide");
    a_pin: assert property (p_pin) else $error("reset pin wrong");
    a_pulse: assert property (p_pulse) else $error("reset pulse length");
    a_ihold: assert property (p_ihold) else $error("interval flag lost");
    a_whold: assert property (p_whold) else $error("watchdog flag lost");
endmodule // itw_checker
bind itw_top itw_checker u_itw_checker (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .interval_irq_ack(interval_irq_ack), .watchdog_irq_ack(watchdog_irq_ack),
    .interval_overflow_flag(interval_overflow_flag), .watchdog_irq_flag(watchdog_irq_flag),
    .wdt_reset_req(wdt_reset_req), .reset_pin_o(reset_pin_o), .reset_pin_oe(reset_pin_oe));

// ---- itw_pkg.sv ----
// package: register map, field positions, reset values and counts for the interval timer / watchdog
package itw_pkg;
    // register byte addresses on the apb bus
    localparam logic [11:0] ITW_ADDR_CTRL = 12'h000;
    localparam logic [11:0] ITW_ADDR_WDT = 12'h004;
    localparam logic [11:0] ITW_ADDR_STAT = 12'h008;
    // clock control word fields
    localparam int ITW_DIV_LSB = 0;
    localparam int ITW_CLR_BIT = 3;
    localparam int ITW_WDRST_BIT = 4;
    localparam int ITW_RCSEL_BIT = 5;
    // watchdog compare register fields
    localparam int ITW_WCLR_BIT = 7;
    // status register fields (the two flag bits write one to clear)
    localparam int ITW_ST_IOF_BIT = 0;
    localparam int ITW_ST_WIF_BIT = 1;
    localparam int ITW_ST_STOP_BIT = 2;
    localparam int ITW_ST_RCMODE_BIT = 3;
    localparam int ITW_ST_WDCNT_LSB = 8;
    // reset values
    localparam logic [7:0] ITW_CTRL_RST = 8'h00;
    localparam logic [7:0] ITW_WDT_RST = 8'h7F;
    // smallest prescaler ratio is 2**3
    localparam int ITW_DIV_BASE_LOG2 = 3;
    localparam int ITW_PRESC_W = 10;
    // length of the watchdog reset pulse, in clock cycles
    localparam int ITW_RST_PULSE_CYC = 16;
    localparam logic [4:0] ITW_RST_PULSE_LAST = 5'(ITW_RST_PULSE_CYC - 1);
endpackage

// ---- itw_tick_if.sv ----
// interface: time-base ticks shared between the interval counter and the watchdog
`timescale 1ns/1ps
interface itw_tick_if;
    logic ovf_tick;
    logic cleared;
    modport src (output ovf_tick, output cleared);
    modport dst (input ovf_tick, input cleared);
endinterface

// ---- itw_top.sv ----
// module: free-running interval timer with prescaler, apb registers and watchdog
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module itw_top (
    // apb clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // power state and rc oscillator tick (asynchronous)
    input wire logic stop_mode,
    input wire logic rc_osc_clk,
    input wire logic sub_clock_mode,
    // interrupt acknowledges from the interrupt controller
    input wire logic interval_irq_ack,
    input wire logic watchdog_irq_ack,
    // events and pins
    output logic interval_overflow_flag,
    output logic watchdog_irq_flag,
    output logic wdt_reset_req,
    output logic reset_pin_o,
    output logic reset_pin_oe,
    output logic main_osc_on,
    output logic rc_watchdog_mode
);
    import itw_pkg::*;

    //////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [9:0] div_mask(input logic [2:0] sel);
        div_mask = 10'((11'h008 << sel) - 11'h001);
    endfunction

    function automatic logic is_addr(input logic [11:0] a, input logic [11:0] ref_a);
        is_addr = (a == ref_a);
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // input synchronisers
    logic [2:0] async_in;
    logic [2:0] sync_s;
    logic rc_prev_q;
    logic stop_s;
    logic rc_s;
    logic sub_s;

    assign async_in = {sub_clock_mode, rc_osc_clk, stop_mode};

    // one two-flop stage per pin; only the second flop is ever read
    for (genvar gi = 0; gi < 3; gi++) begin : g_sync
        logic meta_q;
        logic held_q;
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                meta_q <= 1'b0;
                held_q <= 1'b0;
            end else begin
                meta_q <= async_in[gi];
                held_q <= meta_q;
            end
        end
        assign sync_s[gi] = held_q;
    end

    assign stop_s = sync_s[0];
    assign rc_s = sync_s[1];
    assign sub_s = sync_s[2];

    // rc edge detector; both flops reset low like the idle pin, so no false edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rc_prev_q <= 1'b0;
        end else begin
            rc_prev_q <= rc_s;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0] ctrl_q;
    logic [6:0] cmp_q;
    logic int_clr_q;
    logic wd_clr_q;
    logic iof_q;
    logic wif_q;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic wr_ctrl;
    logic wr_wdt;
    logic wr_stat;
    logic [2:0] div_sel;
    logic rc_sel;
    logic rst_sel;

    assign addr_ok = is_addr(paddr, ITW_ADDR_CTRL) || is_addr(paddr, ITW_ADDR_WDT) || is_addr(paddr, ITW_ADDR_STAT);
    // writes need byte lane 0, where every 8-bit register sits
    assign wr_en = psel && penable && pwrite && addr_ok && pstrb[0];
    assign rd_en = psel && penable && !pwrite;
    assign wr_ctrl = wr_en && is_addr(paddr, ITW_ADDR_CTRL);
    assign wr_wdt = wr_en && is_addr(paddr, ITW_ADDR_WDT);
    assign wr_stat = wr_en && is_addr(paddr, ITW_ADDR_STAT);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    assign div_sel = ctrl_q[ITW_DIV_LSB +: 3];
    assign rc_sel = ctrl_q[ITW_RCSEL_BIT];
    assign rst_sel = ctrl_q[ITW_WDRST_BIT];

    // clear bits are not stored: they live one cycle as pulses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= ITW_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_q <= pwdata[7:0] & ~(8'h01 << ITW_CLR_BIT);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_clr_q <= 1'b0;
        end else begin
            int_clr_q <= wr_ctrl && pwdata[ITW_CLR_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_q <= ITW_WDT_RST[6:0];
            wd_clr_q <= 1'b0;
        end else begin
            wd_clr_q <= wr_wdt && pwdata[ITW_WCLR_BIT];
            if (wr_wdt) begin
                cmp_q <= pwdata[6:0];
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // mode: rc watchdog mode entered on stop while rc select is set
    logic rc_mode;
    assign rc_mode = stop_s && rc_sel;
    assign rc_watchdog_mode = rc_mode;

    //////////////////////////////////////////////////////////////////////////
    // prescaler and interval counter
    logic [ITW_PRESC_W-1:0] presc_q;
    logic [7:0] icnt_q;
    logic src_tick;
    logic presc_full;
    logic presc_pulse;
    logic icnt_run;
    logic ovf_tick;
    itw_tick_if tick_bus ();

    // rc source is counted on its synchronised rising edge, so the rc clock must be well below pclk/4
    assign src_tick = rc_sel ? (rc_s && !rc_prev_q) : 1'b1;
    // main clock is gated in stop; the rc oscillator keeps running
    assign icnt_run = rc_sel ? 1'b1 : !stop_s;
    assign presc_full = (presc_q & div_mask(div_sel)) == div_mask(div_sel);
    // rc watchdog mode bypasses the prescaler, so one overflow is 2^8 rc periods
    assign presc_pulse = icnt_run && src_tick && (rc_mode || presc_full);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_q <= '0;
        end else if (int_clr_q) begin
            presc_q <= '0;
        end else if (icnt_run && src_tick) begin
            presc_q <= presc_q + 10'h001;
        end
    end

    // no enable bit exists: the counter only ever clears or counts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            icnt_q <= 8'h00;
        end else if (int_clr_q) begin
            icnt_q <= 8'h00;
        end else if (presc_pulse) begin
            icnt_q <= icnt_q + 8'h01;
        end
    end

    // a clear in the same cycle swallows the wrap
    assign ovf_tick = presc_pulse && !int_clr_q && (icnt_q == 8'hFF);
    assign tick_bus.ovf_tick = ovf_tick;
    assign tick_bus.cleared = int_clr_q;

    //////////////////////////////////////////////////////////////////////////
    // watchdog
    logic wd_fire;
    logic wd_run;
    logic [6:0] wd_count;

    // in rc mode the overflow period is rc*2^8 at divide 1; outside it, stop freezes the count
    assign wd_run = rc_mode || !stop_s;

    itw_watchdog u_wdt (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick_bus),
        .run(wd_run),
        .wd_clear(wd_clr_q),
        .compare(cmp_q),
        .count(wd_count),
        .fire(wd_fire)
    );

    //////////////////////////////////////////////////////////////////////////
    // flags: set wins over clear
    logic ack_iof;
    logic ack_wif;
    // the interrupt controller's acknowledge and a status write both clear
    assign ack_iof = interval_irq_ack || (wr_stat && pwdata[ITW_ST_IOF_BIT]);
    assign ack_wif = watchdog_irq_ack || (wr_stat && pwdata[ITW_ST_WIF_BIT]);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            iof_q <= 1'b0;
        end else if (ovf_tick) begin
            iof_q <= 1'b1;
        end else if (ack_iof) begin
            iof_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wif_q <= 1'b0;
        end else if (wd_fire && !rst_sel) begin
            wif_q <= 1'b1;
        end else if (ack_wif) begin
            wif_q <= 1'b0;
        end
    end

    assign interval_overflow_flag = iof_q;
    assign watchdog_irq_flag = wif_q;

    //////////////////////////////////////////////////////////////////////////
    // watchdog reset pulse, drives reset pin low and, in sub clock mode, restarts the main oscillator
    // a fire during the pulse restarts it rather than stacking a second one
    logic [4:0] rst_cnt_q;
    logic rst_act_q;
    logic osc_on_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_act_q <= 1'b0;
            rst_cnt_q <= 5'h00;
        end else if (wd_fire && rst_sel) begin
            rst_act_q <= 1'b1;
            rst_cnt_q <= 5'h00;
        end else if (rst_act_q) begin
            if (rst_cnt_q == ITW_RST_PULSE_LAST) begin
                rst_act_q <= 1'b0;
            end
            rst_cnt_q <= rst_cnt_q + 5'h01;
        end
    end

    // oscillator request holds after the pulse until sub clock mode is left
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_on_q <= 1'b0;
        end else if (rst_act_q && sub_s) begin
            osc_on_q <= 1'b1;
        end else if (!sub_s) begin
            osc_on_q <= 1'b0;
        end
    end

    // the pin is only ever pulled low, never driven high
    assign wdt_reset_req = rst_act_q;
    assign reset_pin_o = 1'b0;
    assign reset_pin_oe = rst_act_q;
    assign main_osc_on = osc_on_q;

    //////////////////////////////////////////////////////////////////////////
    // read data, registered; the control address reads back the counter
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [31:0] stat_word;

    always_comb begin
        stat_word = 32'h0000_0000;
        stat_word[ITW_ST_IOF_BIT] = iof_q;
        stat_word[ITW_ST_WIF_BIT] = wif_q;
        stat_word[ITW_ST_STOP_BIT] = stop_s;
        stat_word[ITW_ST_RCMODE_BIT] = rc_mode;
        stat_word[ITW_ST_WDCNT_LSB +: 7] = wd_count;
    end

    // unmapped addresses read as zero
    always_comb begin
        if (is_addr(paddr, ITW_ADDR_CTRL)) begin
            rdata_d = {24'h00_0000, icnt_q};
        end else if (is_addr(paddr, ITW_ADDR_WDT)) begin
            rdata_d = {24'h00_0000, 1'b0, cmp_q};
        end else if (is_addr(paddr, ITW_ADDR_STAT)) begin
            rdata_d = stat_word;
        end else begin
            rdata_d = 32'h0000_0000;
        end
    end

    // snapshot in setup so a counter step between the two phases cannot tear a read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            rdata_q <= rdata_d;
        end
    end

    assign prdata = rd_en ? rdata_q : 32'h0000_0000;
endmodule // itw_top

// ---- itw_top_tb.sv ----
// testbench: apb-driven checks of interval counter, flags and watchdog
`timescale 1ns/1ps
module itw_top_tb;
    import itw_pkg::*;
    typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [3:0] s; logic [31:0] r; logic e;} itw_row_s;
    logic pclk = 0;
    logic presetn = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [3:0] pstrb = 4'hF;
    logic stop_mode = 0;
    logic rc_osc_clk = 0;
    logic sub_clock_mode = 0;
    logic interval_irq_ack = 0;
    logic watchdog_irq_ack = 0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, interval_overflow_flag, watchdog_irq_flag;
    logic wdt_reset_req, reset_pin_o, reset_pin_oe, main_osc_on, rc_watchdog_mode;
    logic [2:0] rcdiv = '0;
    int cyc = 0;
    int t, n, m, fail_count = 0, comparisons = 0;
    itw_row_s rows [8] = '{'{0, ITW_ADDR_WDT, 0, 4'hF, 32'h7F, 0}, '{0, ITW_ADDR_STAT, 0, 4'hF, 32'h0, 0},
        '{1, ITW_ADDR_WDT, 32'h85, 4'hF, 0, 0}, '{0, ITW_ADDR_WDT, 0, 4'hF, 32'h05, 0},
        '{1, ITW_ADDR_WDT, 32'h03, 4'h0, 0, 0}, '{0, ITW_ADDR_WDT, 0, 4'hF, 32'h05, 0},
        '{1, 12'h00C, 32'h01, 4'hF, 0, 1}, '{0, 12'h00C, 0, 4'hF, 32'h0, 1}};
    itw_top u_itw_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .stop_mode(stop_mode), .rc_osc_clk(rc_osc_clk), .sub_clock_mode(sub_clock_mode),
        .interval_irq_ack(interval_irq_ack), .watchdog_irq_ack(watchdog_irq_ack),
        .interval_overflow_flag(interval_overflow_flag), .watchdog_irq_flag(watchdog_irq_flag),
        .wdt_reset_req(wdt_reset_req), .reset_pin_o(reset_pin_o), .reset_pin_oe(reset_pin_oe),
        .main_osc_on(main_osc_on), .rc_watchdog_mode(rc_watchdog_mode));
    always #2.5 pclk = ~pclk;
    // rc oscillator at pclk/8, well under the pclk/4 limit
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        rcdiv <= rcdiv + 3'h1;
        rc_osc_clk <= rcdiv[2];
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [31:0] s, input logic [31:0] x);
        comparisons++;
        if (s !== x) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, x, s);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        t = cyc;
        psel <= 0;
        penable <= 0;
    endtask
    // prescaler phase unknown, so one count of slack
    task automatic rate(input int p);
        logic [7:0] v;
        int t0;
        apb(0, ITW_ADDR_CTRL, 32'h0, 4'hF);
        v = rd[7:0];
        t0 = t;
        repeat (p * 6) @(posedge pclk);
        apb(0, ITW_ADDR_CTRL, 32'h0, 4'hF);
        v = rd[7:0] - v;
        check("rate", 32'(v == 8'((t - t0) / p) || v == 8'((t - t0) / p + 1)), 32'h1);
    endtask
    task automatic ack(input logic wd);
        @(posedge pclk);
        if (wd) watchdog_irq_ack <= 1; else interval_irq_ack <= 1;
        @(posedge pclk);
        watchdog_irq_ack <= 0;
        interval_irq_ack <= 0;
        @(posedge pclk);
        #1;
    endtask
    task automatic finish_test;
        if (fail_count == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge pclk);
        fail_count++;
        finish_test;
    end
    initial begin
        repeat (5) @(posedge pclk);
        check("rst_req", 32'(wdt_reset_req), 32'h0);
        presetn <= 1;
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d, rows[i].s);
            if (!rows[i].w) check("row_rd", rd, rows[i].r);
            check("row_err", 32'(er), 32'(rows[i].e));
        end
        for (int k = 0; k < 8; k++) begin
            apb(1, ITW_ADDR_CTRL, 32'(k), 4'hF);
            rate(8 << k);
        end
        apb(1, ITW_ADDR_CTRL, 32'h0F, 4'hF);
        apb(0, ITW_ADDR_CTRL, 32'h0, 4'hF);
        check("clear", 32'(rd[7:1]), 32'h0);
        apb(1, ITW_ADDR_CTRL, 32'h08, 4'hF);
        n = 0;
        while (interval_overflow_flag !== 1'b1 && n < 2200) begin @(posedge pclk); n++; end
        check("wrap", 32'(n > 2030 && n < 2060), 32'h1);
        apb(0, ITW_ADDR_STAT, 32'h0, 4'hF);
        check("st_iof", 32'(rd[ITW_ST_IOF_BIT]), 32'h1);
        ack(0);
        check("iack", 32'(interval_overflow_flag), 32'h0);
        apb(1, ITW_ADDR_WDT, 32'h81, 4'hF);
        n = 0;
        while (watchdog_irq_flag !== 1'b1 && n < 4300) begin @(posedge pclk); n++; end
        check("wd_period", 32'(n > 2030 && n < 4110), 32'h1);
        apb(1, ITW_ADDR_STAT, 32'h2, 4'hF);
        apb(0, ITW_ADDR_STAT, 32'h0, 4'hF);
        check("st_clr", 32'(rd[ITW_ST_WIF_BIT]), 32'h0);
        // software kicks the watchdog well inside its two-overflow window
        for (int k = 0; k < 5; k++) begin
            apb(1, ITW_ADDR_WDT, 32'h81, 4'hF);
            repeat (1500) @(posedge pclk);
        end
        check("kicked", 32'(watchdog_irq_flag), 32'h0);
        sub_clock_mode <= 1;
        apb(1, ITW_ADDR_CTRL, 32'h10, 4'hF);
        apb(1, ITW_ADDR_WDT, 32'h80, 4'hF);
        n = 0;
        while (wdt_reset_req !== 1'b1 && n < 2200) begin @(posedge pclk); n++; end
        m = 0;
        while (wdt_reset_req === 1'b1 && m < 40) begin @(posedge pclk); m++; end
        check("rst_len", 32'(m), 32'(ITW_RST_PULSE_CYC));
        check("no_wflag", 32'(watchdog_irq_flag), 32'h0);
        check("osc_on", 32'(main_osc_on), 32'h1);
        sub_clock_mode <= 0;
        apb(1, ITW_ADDR_CTRL, 32'h00, 4'hF);
        // the sub clock level needs two synchroniser stages before the request drops
        repeat (2) @(posedge pclk);
        check("osc_rel", 32'(main_osc_on), 32'h0);
        stop_mode <= 1;
        repeat (8) @(posedge pclk);
        apb(0, ITW_ADDR_CTRL, 32'h0, 4'hF);
        m = rd;
        repeat (100) @(posedge pclk);
        apb(0, ITW_ADDR_CTRL, 32'h0, 4'hF);
        check("stop_hold", rd, 32'(m));
        check("no_rcmode", 32'(rc_watchdog_mode), 32'h0);
        stop_mode <= 0;
        apb(1, ITW_ADDR_CTRL, 32'h20, 4'hF);
        rate(64);
        stop_mode <= 1;
        repeat (8) @(posedge pclk);
        check("rcmode", 32'(rc_watchdog_mode), 32'h1);
        rate(8);
        stop_mode <= 0;
        finish_test;
    end
endmodule // itw_top_tb

// ---- itw_watchdog.sv ----
// module: 7-bit watchdog counter with compare and activation pulse
`timescale 1ns/1ps
module itw_watchdog (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // time base
    itw_tick_if.dst tick,
    // control
    input wire logic run,
    input wire logic wd_clear,
    input wire logic [6:0] compare,
    // result
    output logic [6:0] count,
    output logic fire
);
    import itw_pkg::*;

    logic [6:0] cnt_q;
    logic armed_q;

    // counting only starts once the interval counter has been cleared
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed_q <= 1'b0;
        end else if (tick.cleared) begin
            armed_q <= 1'b1;
        end
    end

    // clear wins over counting; a match restarts from zero so the period is compare+1
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 7'h00;
        end else if (wd_clear) begin
            cnt_q <= 7'h00;
        end else if (run && armed_q && tick.ovf_tick) begin
            if (cnt_q == compare) begin
                cnt_q <= 7'h00;
            end else begin
                cnt_q <= cnt_q + 7'h01;
            end
        end
    end

    assign fire = run && armed_q && tick.ovf_tick && !wd_clear && (cnt_q == compare);
    assign count = cnt_q;
endmodule // itw_watchdog
